//--- bench/irpdc_ctrl_assertions.sv
`timescale 1ns/10ps
module irpdc_ctrl_assertions (
  // Watched ports
  input wire clk,
  input wire reset_n,
  input wire envOut,
  input wire envOe,
  input wire carOe,
  input wire cmdSleep,
  input wire configReady,
  input wire asleep,
  input wire busy,
  input wire detValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Pin steps of a command
  sequence envLow;
    envOe && !envOut;
  endsequence
  sequence bothFree;
    !envOe && !carOe;
  endsequence
  pins_free_a: assert property (!busy && !asleep |-> bothFree) else $error("pins driven while idle");
  no_config_a: assert property (!configReady |-> bothFree) else $error("drive before light");
  car_order_a: assert property ($rose(carOe) |-> envLow) else $error("carrier low out of order");
  env_high_a: assert property ($rose(envOut) |-> carOe && envOe) else $error("envelope high early");
  prompt_free_a: assert property ($rose(envOut) |-> ##[1:30] bothFree) else $error("pins held too long");
  sleep_drv_a: assert property (asleep |-> envLow) else $error("sleep drive lost");
  sleep_take_a: assert property (cmdSleep && !busy && configReady |=> envLow) else $error("sleep not taken");
  recov_a: assert property ($fell(asleep) |-> !detValid [*8]) else $error("valid during recovery");
  wake_step_a: assert property ($fell(asleep) |-> carOe ##0 envLow) else $error("wake order broken");
  valid_free_a: assert property (detValid |-> !busy ##0 bothFree) else $error("valid while driving");
endmodule // irpdc_ctrl_assertions
bind irpdc_ctrl irpdc_ctrl_assertions i_chk (.clk, .reset_n, .envOut, .envOe, .carOe, .cmdSleep, .configReady,
  .asleep, .busy, .detValid);

//--- bench/irpdc_dev_model.sv
`timescale 1ns/10ps
module irpdc_dev_model (
  // Light and pins
  input wire clk,
  input wire light,
  input wire envPin,
  input wire carPin,
  input wire hostOe,
  // Device drive
  output wire devOe,
  output wire devEnv,
  output reg devCar
);
  reg sleeping = 1'b0;
  // Commands arrive on the shared pins
  always @(posedge clk) begin
    if (hostOe && !envPin) sleeping <= 1'b1;
    if (hostOe && !carPin) sleeping <= 1'b0;
  end
  // Carrier toggles only in light, so it idles low
  always @(posedge clk) devCar <= light & ~devCar;
  // Envelope tracks light at threshold
  assign devEnv = light;
  assign devOe = !hostOe && !sleeping;
endmodule // irpdc_dev_model

//--- bench/tb.sv
`timescale 1ns/10ps
`include "irpdc_consts.vh"
module tb;
  // Short recovery window keeps the run small
  localparam integer REC_CYC = 20;
  reg clk = 1'b0, reset_n = 1'b0, light = 1'b0, cmdWatch = 1'b0, cmdSleep = 1'b0, cmdWake = 1'b0;
  wire envOut, envOe, carOut, carOe, configReady, asleep, busy, detValid, envelope, carrier, devOe, devEnv, devCar;
  integer fail_count = 0, check_count = 0, cyc = 0;
  // Envelope pulled up, carrier pulled down when nobody drives
  wire envIn = envOe ? envOut : (devOe ? devEnv : 1'b1);
  wire carIn = carOe ? carOut : (devOe ? devCar : 1'b0);
  irpdc_ctrl #(.RECOVERY_CYC(REC_CYC)) i_dut (.clk, .reset_n, .envIn, .envOut, .envOe, .carIn, .carOut, .carOe,
    .cmdWatch, .cmdSleep, .cmdWake, .configReady, .asleep, .busy, .detValid, .envelope, .carrier);
  irpdc_dev_model i_dev (.clk, .light, .envPin(envIn), .carPin(carIn), .hostOe(envOe | carOe), .devOe,
    .devEnv, .devCar);
  initial forever #4 clk = ~clk;
  task stop_test; begin
    $display("fails %0d checks %0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end endtask
  task chk(input logic got, input logic exp); begin
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t mismatch", $time);
    end
  end endtask
  // Bounded wait, so a stuck sequence still ends the test
  task idle; integer i; begin
    for (i = 0; i < 60 && busy !== 1'b0; i++) @(negedge clk);
  end endtask
  // Commands are refused until first light; busy stays up meanwhile
  task t_unconf; reg prevCar; begin
    cmdWatch = 1;
    @(negedge clk) cmdWatch = 0;
    repeat (3) @(negedge clk);
    chk(busy, 1);
    chk(configReady, 0);
    chk(envOe, 0);
    chk(carOe, 0);
    light = 1;
    repeat (4) @(negedge clk);
    chk(configReady, 1);
    chk(envelope, 1);
    prevCar = carrier;
    @(negedge clk) chk(carrier, !prevCar);
    light = 0;
    repeat (3) @(negedge clk);
    chk(envelope, 0);
    chk(carrier, 0);
    $display("unconf done");
  end endtask
  // The first two pin steps must each hold at least one step time
  task t_watch; integer n; begin
    cmdWatch = 1;
    @(negedge clk) cmdWatch = 0;
    chk(busy, 1);
    chk(envIn, 0);
    chk(carOe, 0);
    for (n = 0; n < 60 && carOe !== 1'b1; n++) @(negedge clk);
    chk(carOe, 1);
    chk(n >= `IRPDC_STEP_CYC, 1);
    chk(envIn, 0);
    chk(carIn, 0);
    for (n = 0; n < 60 && envIn !== 1'b1; n++) @(negedge clk);
    chk(envOe, 1);
    chk(carIn, 0);
    chk(n >= `IRPDC_STEP_CYC, 1);
    idle;
    chk(envOe, 0);
    chk(carOe, 0);
    @(negedge clk) chk(detValid, 1);
    $display("watch done");
  end endtask
  // Results stay invalid for the whole recovery window after wake
  task t_sleep; integer n; begin
    cmdSleep = 1;
    @(negedge clk) cmdSleep = 0;
    repeat (2) @(negedge clk);
    chk(asleep, 1);
    chk(envIn, 0);
    chk(carOe, 0);
    cmdWatch = 1;
    @(negedge clk) cmdWatch = 0;
    chk(asleep, 1);
    cmdWake = 1;
    for (n = 0; n < 60 && carOe !== 1'b1; n++) @(negedge clk);
    cmdWake = 0;
    chk(asleep, 0);
    chk(envIn, 0);
    chk(carIn, 0);
    light = 1;
    for (n = 0; n < 60 && carOe !== 1'b0; n++) @(negedge clk);
    chk(envOe, 0);
    chk(envIn, 1);
    chk(envelope, 0);
    chk(detValid, 0);
    for (n = 0; n < 200 && detValid !== 1'b1; n++) @(negedge clk);
    chk(detValid, 1);
    chk(n >= REC_CYC, 1);
    chk(envelope, 1);
    light = 0;
    $display("sleep done");
  end endtask
  // A mid-run reset forgets the first light and releases the pins
  task t_reset; begin
    @(negedge clk) reset_n = 0;
    repeat (2) @(negedge clk);
    chk(configReady, 0);
    chk(envOe, 0);
    chk(busy, 0);
    reset_n = 1;
    repeat (2) @(negedge clk);
    chk(busy, 1);
    chk(configReady, 0);
    light = 1;
    repeat (4) @(negedge clk);
    chk(configReady, 1);
    light = 0;
    $display("reset done");
  end endtask
  // Whole run needs well under 1000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1;
    t_unconf;
    t_watch;
    t_sleep;
    t_reset;
    stop_test;
  end
endmodule // tb

//--- design/irpdc_ctrl.v
`timescale 1ns/10ps
`include "irpdc_consts.vh"
module irpdc_ctrl #(
  parameter RECOVERY_CYC = `IRPDC_RECOVERY_CYC,
  parameter STEP_CYC = `IRPDC_STEP_CYC
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Envelope pin
  input wire envIn,
  output reg envOut,
  output reg envOe,
  // Carrier pin
  input wire carIn,
  output reg carOut,
  output reg carOe,
  // User commands, one-cycle pulses
  input wire cmdWatch,
  input wire cmdSleep,
  input wire cmdWake,
  // User status
  output reg configReady,
  output reg asleep,
  output reg busy,
  output reg detValid,
  output reg envelope,
  output reg carrier
);
  // One-hot sequencer states
  localparam S_UNCONF = 8'h01;
  localparam S_IDLE = 8'h02;
  localparam S_W1 = 8'h04;
  localparam S_W2 = 8'h08;
  localparam S_W3 = 8'h10;
  localparam S_SLEEP = 8'h20;
  localparam S_K1 = 8'h40;
  localparam S_REC = 8'h80;
  localparam CW = `IRPDC_CNT_W;

  // Sequencer, first-light flag and recovery window
  reg [7:0] state;
  reg [7:0] next_state;
  reg sawLight;
  reg [CW-1:0] recCount;
  reg tLoad;
  reg [CW-1:0] tValue;
  wire tDone;

  // Pin steps are paced by one timer; the recovery window counts down in recCount
  irpdc_step_timer #(.CNT_W(CW)) stepTimer (
    .clk(clk),
    .reset_n(reset_n),
    .load(tLoad),
    .loadValue(tValue),
    .done(tDone)
  );

  // Sequencer next state and timer loads
  always @* begin
    next_state = state;
    tLoad = 1'b0;
    tValue = STEP_CYC[CW-1:0];
    case (state)
      // Pins stay released until the device has seen light once
      S_UNCONF: begin
        if (sawLight) begin
          next_state = S_IDLE;
        end
      end
      // Released; sleep wins when both commands come together
      S_IDLE: begin
        if (cmdSleep) begin
          next_state = S_SLEEP;
          tLoad = 1'b1;
        end else if (cmdWatch) begin
          next_state = S_W1;
          tLoad = 1'b1;
        end
      end
      // Envelope held low for one step
      S_W1: begin
        if (tDone) begin
          next_state = S_W2;
          tLoad = 1'b1;
        end
      end
      // Carrier pulled low behind the low envelope
      S_W2: begin
        if (tDone) begin
          next_state = S_W3;
          tLoad = 1'b1;
        end
      end
      // Envelope back high for one step, then both released
      S_W3: begin
        if (tDone) begin
          next_state = S_IDLE;
        end
      end
      // Wake waits one step so a short sleep still meets the pin timing
      S_SLEEP: begin
        if (cmdWake && tDone) begin
          next_state = S_K1;
          tLoad = 1'b1;
        end
      end
      // Carrier low while the envelope is still held low
      S_K1: begin
        if (tDone) begin
          next_state = S_REC;
        end
      end
      // Released; outputs ignored until the window runs out
      S_REC: begin
        if (recCount == {CW{1'b0}}) begin
          next_state = S_IDLE;
        end
      end
      // Unused codes fall back to the power-on state
      default: begin
        next_state = S_UNCONF;
      end
    endcase
  end

  // State, pin drive and status registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_UNCONF;
      sawLight <= 1'b0;
      recCount <= {CW{1'b0}};
      envOut <= 1'b0;
      envOe <= 1'b0;
      carOut <= 1'b0;
      carOe <= 1'b0;
      configReady <= 1'b0;
      asleep <= 1'b0;
      busy <= 1'b0;
      detValid <= 1'b0;
      envelope <= 1'b0;
      carrier <= 1'b0;
    end else begin
      state <= next_state;
      // First light seen as envelope high while pins are released
      if (envIn && state == S_UNCONF) begin
        sawLight <= 1'b1;
      end
      // Recovery window starts as the wake step ends
      if (state == S_K1 && tDone) begin
        recCount <= RECOVERY_CYC[CW-1:0];
      end else if (recCount != {CW{1'b0}}) begin
        recCount <= recCount - {{(CW-1){1'b0}}, 1'b1};
      end
      // Pin drive per state; released elsewhere
      case (next_state)
        // First step: envelope low
        S_W1: begin
          envOe <= 1'b1;
          envOut <= 1'b0;
          carOe <= 1'b0;
          carOut <= 1'b0;
        end
        // Second step: carrier low under a low envelope
        S_W2: begin
          envOe <= 1'b1;
          envOut <= 1'b0;
          carOe <= 1'b1;
          carOut <= 1'b0;
        end
        // Third step: envelope driven back high
        S_W3: begin
          envOe <= 1'b1;
          envOut <= 1'b1;
          carOe <= 1'b1;
          carOut <= 1'b0;
        end
        // Envelope held low for the whole sleep
        S_SLEEP: begin
          envOe <= 1'b1;
          envOut <= 1'b0;
          carOe <= 1'b0;
          carOut <= 1'b0;
        end
        // Wake step: carrier low, envelope still low
        S_K1: begin
          envOe <= 1'b1;
          envOut <= 1'b0;
          carOe <= 1'b1;
          carOut <= 1'b0;
        end
        // Released so the device can answer on both pins
        default: begin
          envOe <= 1'b0;
          envOut <= 1'b0;
          carOe <= 1'b0;
          carOut <= 1'b0;
        end
      endcase
      // Status follows the next state so it lines up with the pins
      // Busy stays high through recovery, so callers just wait on it
      configReady <= (next_state != S_UNCONF);
      asleep <= (next_state == S_SLEEP);
      busy <= (next_state != S_IDLE);
      // Results only trusted while idle and released
      detValid <= (state == S_IDLE) && (next_state == S_IDLE);
      envelope <= (state == S_IDLE) && envIn;
      carrier <= (state == S_IDLE) && carIn;
    end
  end
endmodule // irpdc_ctrl

//--- design/irpdc_step_timer.v
`timescale 1ns/10ps
`include "irpdc_consts.vh"
module irpdc_step_timer #(
  parameter CNT_W = `IRPDC_CNT_W
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Control
  input wire load,
  input wire [CNT_W-1:0] loadValue,
  // Status
  output reg done
);
  reg [CNT_W-1:0] count;

  // Down counter; done is high while idle at zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= {CNT_W{1'b0}};
      done <= 1'b1;
    end else if (load) begin
      count <= loadValue;
      done <= 1'b0;
    end else if (count != {CNT_W{1'b0}}) begin
      count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
      done <= (count == {{(CNT_W-1){1'b0}}, 1'b1});
    end else begin
      done <= 1'b1;
    end
  end
endmodule // irpdc_step_timer

//--- inc/irpdc_consts.vh
`ifndef IRPDC_CONSTS_VH
`define IRPDC_CONSTS_VH
// Clock rate in MHz (period 8 ns)
`define IRPDC_CLK_MHZ 125
// Sleep recovery window, microseconds
`define IRPDC_RECOVERY_US 50
// Recovery window in cycles
`define IRPDC_RECOVERY_CYC (`IRPDC_RECOVERY_US * `IRPDC_CLK_MHZ)
// Least pin step hold, nanoseconds (start/end spacing)
`define IRPDC_STEP_NS 80
// Step hold in cycles, rounded up
`define IRPDC_STEP_CYC ((`IRPDC_STEP_NS * `IRPDC_CLK_MHZ + 999) / 1000)
// Carrier one-shot timeout, longest bound in ns
`define IRPDC_ONESHOT_NS 900
`define IRPDC_ONESHOT_CYC ((`IRPDC_ONESHOT_NS * `IRPDC_CLK_MHZ) / 1000)
// Counter width
`define IRPDC_CNT_W 14
`endif
